// [logic/scd_pkg.sv]
/*
 * shared constants and carrier types for the interleaved static-column
 * dram instruction memory controller.
 * assumes a single 20 mhz system clock and a 32-bit byte address.
 */
`default_nettype none
package scd_pkg;
	// byte address fields: bank select, counted bits, latched bits
	localparam int SCD_BANK_BIT = 2;
	localparam int SCD_CNT_LO = 2;
	localparam int SCD_CNT_HI = 9;
	localparam int SCD_MID_LO = 10;
	localparam int SCD_MID_HI = 12;
	localparam int SCD_ROW_LO = 13;
	localparam int SCD_ROW_HI = 22;
	localparam int SCD_SEL_LO = 23;
	localparam int SCD_SEL_HI = 31;
	localparam int SCD_MADDR_W = 10;
	localparam int SCD_DATA_W = 32;
	// refresh interval in system clock cycles
	localparam int SCD_REFRESH_CYCLES = 390;
	localparam int SCD_REFRESH_W = 9;
	localparam int SCD_FIFO_DEPTH = 16;

	typedef enum logic [3:0] {
		idle,
		instr_row_strobe_state,
		instr_column_state,
		instr_transfer_state,
		data_row_strobe_state,
		data_column_state,
		data_read_state,
		data_write_column_state,
		data_write_state,
		write_preempt_first,
		write_preempt_second,
		precharge_state,
		refresh_step_one_state,
		refresh_step_two_state,
		refresh_step_three_state
	} scd_state_type;

	// address decode indications
	typedef struct packed {
		logic instr_hit;
		logic instr_begin;
		logic instr_end;
		logic data_hit;
		logic data_begin;
		logic data_end;
	} scd_decode_type;

	// memory array strobes
	typedef struct packed {
		logic row_strobe_n;
		logic chip_select_n;
		logic write_enable_n;
		logic col_select;
	} scd_mem_ctl_type;
endpackage
`default_nettype wire

// [logic/scd_ctrl.sv]
/*
 * write-data fifo and control sequencer for a two-bank odd/even
 * interleaved static-column dram instruction memory.
 * assumes the processor drives a full address on every new access,
 * synchronous inputs and one clock; array buffers sit outside.
 */
// Behaviour
// [RULE1] two write latch sets, alternate by active bank
// [RULE2] write data stable before and after chip select
// [RULE3] write word taken one cycle before read
// [RULE4] per-bank 8-bit counter, lsb names bank
// [RULE5] upper address latched, transparent during decode
// [RULE6] bits 10-12 with counter, 13-22 own latch
// [RULE7] bank counters advance on different cycles
// [RULE8] column address selected after row strobe delay
// [RULE9] burst requests and bus invalid registered first
// [RULE10] decode shows hit, begin and end per bus
// [RULE11] mealy sequencer of fifteen states
// [RULE12] idle: acks off, no refresh, precharge
// [RULE13] idle goes to instr, data or refresh
// [RULE14] pending refresh wins when leaving idle
// [RULE15] instr row state: ack, row strobe, no ready
// [RULE16] instr row state always then column state
// [RULE17] column state drives chip select, then transfer
// [RULE18] transfer state: enables follow burst request
// [RULE19] transfer leaves on new address or refresh
// [RULE20] separate instruction output enables per bank
// [RULE21] precharge always followed by idle
// [RULE22] refresh request every 390 cycles, flag
// [RULE23] refresh three cycles, first step held throughout
// [RULE24] reset: idle, strobes off, refresh cleared
// [RULE25] processor reissues address at 256-word boundary
`default_nettype none

module scd_fifo #(
	parameter int WIDTH = 32,
	parameter int DEPTH = 16
) (
	input wire logic clk,
	input wire logic reset_n,
	input wire logic clk_en,
	input wire logic in_valid,
	output logic in_ready,
	input wire logic [WIDTH-1:0] in_data,
	output logic out_valid,
	input wire logic out_ready,
	output logic [WIDTH-1:0] out_data
);
	localparam int AW = $clog2(DEPTH);
	logic [WIDTH-1:0] mem [DEPTH];
	logic [AW:0] wr_ptr_reg;
	logic [AW:0] rd_ptr_reg;
	logic push;
	logic pop;

	if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0) begin : g_bad_depth
		$error("fifo depth must be a power of two of at least 2");
	end

	// full when pointers differ only in the wrap bit
	assign in_ready = (wr_ptr_reg ^ rd_ptr_reg) != {1'b1, {AW{1'b0}}};
	assign out_valid = wr_ptr_reg != rd_ptr_reg;
	assign push = in_valid && in_ready;
	assign pop = out_valid && out_ready;
	assign out_data = mem[rd_ptr_reg[AW-1:0]];

	// storage array
	always_ff @(posedge clk) begin
		if (clk_en && push) begin
			mem[wr_ptr_reg[AW-1:0]] <= in_data;
		end
	end

	// pointers
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			wr_ptr_reg <= '0;
			rd_ptr_reg <= '0;
		end else if (clk_en) begin
			if (push) begin
				wr_ptr_reg <= wr_ptr_reg + 1'b1;
			end
			if (pop) begin
				rd_ptr_reg <= rd_ptr_reg + 1'b1;
			end
		end
	end
endmodule

module scd_ctrl #(
	parameter logic [8:0] BLOCK_SELECT = 9'h000,
	parameter int REFRESH_CYCLES = scd_pkg::SCD_REFRESH_CYCLES,
	parameter int FIFO_DEPTH = scd_pkg::SCD_FIFO_DEPTH
) (
	input wire logic clk,
	input wire logic reset_n,
	input wire logic clk_en,
	input wire logic [31:0] addr,
	input wire logic instr_addr_valid,
	input wire logic data_addr_valid,
	input wire logic data_write,
	input wire logic instr_burst_request,
	input wire logic data_burst_request,
	input wire logic bus_invalid,
	input wire logic [31:0] write_data,
	output scd_pkg::scd_decode_type access_decode,
	output scd_pkg::scd_mem_ctl_type mem_ctl,
	output logic [9:0] mem_addr_even,
	output logic [9:0] mem_addr_odd,
	output logic [31:0] mem_wdata_even,
	output logic [31:0] mem_wdata_odd,
	output logic instr_burst_ack,
	output logic data_burst_ack,
	output logic instr_ready,
	output logic data_ready,
	output logic [1:0] instr_oe,
	output logic [1:0] data_oe,
	output logic active_bank_indicator,
	output logic refresh_step_first,
	output logic refresh_step_second,
	output logic refresh_step_third
);
	scd_pkg::scd_state_type state_reg;
	scd_pkg::scd_state_type state_next;
	logic instr_burst_request_reg;
	logic dbreq_reg;
	logic bus_invalid_reg;
	logic write_reg;
	logic refresh_req_reg;
	logic [8:0] ref_cnt_reg;
	logic [7:0] cnt_reg [2];
	logic bank_reg;
	logic [12:0] lat_reg;
	logic [12:0] upper;
	logic col_sel_reg;
	logic wr_arm_reg;
	logic wr_pulse_reg;
	logic [31:0] wlat_reg [2];
	logic match;
	logic instr_hit;
	logic data_hit;
	logic row_active;
	logic cs_read;
	logic leave_instr;
	logic leave_data;
	logic advance;
	logic fifo_in_valid;
	logic fifo_in_ready;
	logic fifo_out_valid;
	logic fifo_out_ready;
	logic [31:0] fifo_out_data;
	logic refresh_tick;

	if (REFRESH_CYCLES < 2 || REFRESH_CYCLES > 512) begin : g_bad_refresh
		$error("refresh interval must fit the 9-bit counter");
	end

	// registered burst requests and bus invalid
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			instr_burst_request_reg <= 1'b0;
			dbreq_reg <= 1'b0;
			bus_invalid_reg <= 1'b1;
		end else if (clk_en) begin
			instr_burst_request_reg <= instr_burst_request; // [RULE9]
			dbreq_reg <= data_burst_request; // [RULE9]
			bus_invalid_reg <= bus_invalid; // [RULE9]
		end
	end

	// address decode for both buses
	assign match = addr[scd_pkg::SCD_SEL_HI:scd_pkg::SCD_SEL_LO] == BLOCK_SELECT;
	assign instr_hit = instr_addr_valid && match;
	assign data_hit = data_addr_valid && match;
	assign access_decode.instr_hit = instr_hit; // [RULE10]
	assign access_decode.data_hit = data_hit; // [RULE10]
	assign access_decode.instr_begin = state_reg == scd_pkg::idle && !refresh_req_reg && instr_hit;
	assign access_decode.data_begin = state_reg == scd_pkg::idle && !refresh_req_reg && !instr_hit && data_hit;
	assign access_decode.instr_end = leave_instr; // [RULE10]
	assign access_decode.data_end = leave_data; // [RULE10]

	// exit conditions out of the transfer states
	assign leave_instr = state_reg == scd_pkg::instr_transfer_state
		&& (instr_addr_valid || data_hit || refresh_req_reg); // [RULE19]
	assign leave_data = (state_reg == scd_pkg::data_read_state && (refresh_req_reg || !dbreq_reg))
		|| (state_reg == scd_pkg::data_write_state && (refresh_req_reg || !dbreq_reg));

	// next state
	always_comb begin
		state_next = state_reg;
		unique case (state_reg)
			scd_pkg::idle: begin
				if (refresh_req_reg) begin
					state_next = scd_pkg::refresh_step_one_state; // [RULE14]
				end else if (instr_hit) begin
					state_next = scd_pkg::instr_row_strobe_state; // [RULE13]
				end else if (data_hit) begin
					state_next = scd_pkg::data_row_strobe_state; // [RULE13]
				end
			end
			scd_pkg::instr_row_strobe_state: state_next = scd_pkg::instr_column_state; // [RULE16]
			scd_pkg::instr_column_state: state_next = scd_pkg::instr_transfer_state; // [RULE17]
			scd_pkg::instr_transfer_state: begin
				if (leave_instr) begin
					state_next = scd_pkg::precharge_state; // [RULE19]
				end
			end
			scd_pkg::data_row_strobe_state: begin
				state_next = write_reg ? scd_pkg::data_write_column_state : scd_pkg::data_column_state;
			end
			scd_pkg::data_column_state: state_next = scd_pkg::data_read_state;
			scd_pkg::data_read_state: begin
				if (leave_data) begin
					state_next = scd_pkg::precharge_state;
				end
			end
			scd_pkg::data_write_column_state: state_next = scd_pkg::data_write_state;
			scd_pkg::data_write_state: begin
				if (refresh_req_reg) begin
					state_next = scd_pkg::write_preempt_first;
				end else if (!dbreq_reg && !fifo_out_valid) begin
					state_next = scd_pkg::precharge_state;
				end
			end
			scd_pkg::write_preempt_first: state_next = scd_pkg::write_preempt_second;
			scd_pkg::write_preempt_second: begin
				if (!fifo_out_valid) begin
					state_next = scd_pkg::precharge_state;
				end
			end
			scd_pkg::precharge_state: state_next = scd_pkg::idle; // [RULE21]
			scd_pkg::refresh_step_one_state: state_next = scd_pkg::refresh_step_two_state; // [RULE23]
			scd_pkg::refresh_step_two_state: state_next = scd_pkg::refresh_step_three_state; // [RULE23]
			scd_pkg::refresh_step_three_state: state_next = scd_pkg::idle; // [RULE23]
			default: state_next = scd_pkg::idle;
		endcase
	end

	// state register and access direction
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			state_reg <= scd_pkg::idle; // [RULE24]
			write_reg <= 1'b0;
		end else if (clk_en) begin
			state_reg <= state_next; // [RULE11]
			if (state_reg == scd_pkg::idle) begin
				write_reg <= data_write;
			end
		end
	end

	// free-running refresh interval counter and request flag
	assign refresh_tick = ref_cnt_reg == 9'(REFRESH_CYCLES - 1);
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			ref_cnt_reg <= '0;
			refresh_req_reg <= 1'b0; // [RULE24]
		end else if (clk_en) begin
			ref_cnt_reg <= refresh_tick ? 9'h000 : ref_cnt_reg + 9'h001; // [RULE22]
			if (refresh_tick) begin
				refresh_req_reg <= 1'b1; // [RULE22]
			end else if (state_reg == scd_pkg::idle) begin
				refresh_req_reg <= 1'b0; // acknowledged by leaving idle
			end
		end
	end

	// refresh step signals, the first one covers all three cycles
	assign refresh_step_first = state_reg == scd_pkg::refresh_step_one_state
		|| refresh_step_second || refresh_step_third; // [RULE23]
	assign refresh_step_second = state_reg == scd_pkg::refresh_step_two_state;
	assign refresh_step_third = state_reg == scd_pkg::refresh_step_three_state;

	// upper address latch, open while decoding in idle
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			lat_reg <= '0;
		end else if (clk_en && state_reg == scd_pkg::idle) begin
			lat_reg <= addr[scd_pkg::SCD_ROW_HI:scd_pkg::SCD_MID_LO]; // [RULE5]
		end
	end
	assign upper = state_reg == scd_pkg::idle ? addr[scd_pkg::SCD_ROW_HI:scd_pkg::SCD_MID_LO] : lat_reg; // [RULE5]

	// a word leaves a bank when the bus takes it, or enters one from the fifo
	assign advance = instr_ready
		|| (data_ready && state_reg == scd_pkg::data_read_state)
		|| (fifo_out_valid && fifo_out_ready);

	// per-bank burst counters, lsb names the bank
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			cnt_reg[0] <= 8'h00;
			cnt_reg[1] <= 8'h01;
			bank_reg <= 1'b0;
		end else if (clk_en) begin
			if (state_reg == scd_pkg::idle) begin
				cnt_reg[0] <= {addr[scd_pkg::SCD_CNT_HI:3] + 7'(addr[scd_pkg::SCD_BANK_BIT]), 1'b0}; // [RULE4]
				cnt_reg[1] <= {addr[scd_pkg::SCD_CNT_HI:3], 1'b1}; // [RULE4]
				bank_reg <= addr[scd_pkg::SCD_BANK_BIT];
			end else if (advance) begin
				cnt_reg[bank_reg] <= cnt_reg[bank_reg] + 8'h02; // [RULE7]
				bank_reg <= !bank_reg;
			end
		end
	end
	assign active_bank_indicator = bank_reg;

	// row/column multiplex, column half selected a cycle after row strobe
	assign row_active = !(state_reg == scd_pkg::idle || state_reg == scd_pkg::precharge_state);
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			col_sel_reg <= 1'b0;
		end else if (clk_en) begin
			col_sel_reg <= row_active; // [RULE8]
		end
	end
	assign mem_addr_even = col_sel_reg ? {upper[2:0], cnt_reg[0][7:1]} : upper[12:3]; // [RULE6]
	assign mem_addr_odd = col_sel_reg ? {upper[2:0], cnt_reg[1][7:1]} : upper[12:3]; // [RULE6]

	// write data fifo, filled early and drained into the bank latches
	assign fifo_in_valid = data_ready && write_reg;
	assign fifo_out_ready = state_reg == scd_pkg::data_write_state
		|| state_reg == scd_pkg::write_preempt_first || state_reg == scd_pkg::write_preempt_second;
	scd_fifo #(
		.WIDTH(scd_pkg::SCD_DATA_W),
		.DEPTH(FIFO_DEPTH)
	) u_wfifo (
		.clk(clk),
		.reset_n(reset_n),
		.clk_en(clk_en),
		.in_valid(fifo_in_valid),
		.in_ready(fifo_in_ready),
		.in_data(write_data),
		.out_valid(fifo_out_valid),
		.out_ready(fifo_out_ready),
		.out_data(fifo_out_data)
	);

	// bank write latches open on alternate words; strobe follows a cycle later
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			wlat_reg[0] <= '0;
			wlat_reg[1] <= '0;
			wr_arm_reg <= 1'b0;
			wr_pulse_reg <= 1'b0;
		end else if (clk_en) begin
			if (fifo_out_valid && fifo_out_ready) begin
				wlat_reg[bank_reg] <= fifo_out_data; // [RULE1]
			end
			wr_arm_reg <= fifo_out_valid && fifo_out_ready;
			wr_pulse_reg <= wr_arm_reg; // [RULE2]
		end
	end
	assign mem_wdata_even = wlat_reg[0];
	assign mem_wdata_odd = wlat_reg[1];

	// strobes toward the array
	assign cs_read = state_reg == scd_pkg::instr_column_state || state_reg == scd_pkg::instr_transfer_state
		|| state_reg == scd_pkg::data_column_state || state_reg == scd_pkg::data_read_state;
	assign mem_ctl.row_strobe_n = !row_active;
	assign mem_ctl.chip_select_n = !(cs_read || wr_pulse_reg
		|| (state_reg == scd_pkg::idle && refresh_req_reg)); // [RULE17]
	assign mem_ctl.write_enable_n = !wr_pulse_reg; // [RULE2]
	assign mem_ctl.col_select = col_sel_reg;

	// burst acknowledges, dropped in the cycle that preempts
	assign instr_burst_ack = (state_reg == scd_pkg::instr_row_strobe_state
		|| state_reg == scd_pkg::instr_column_state
		|| state_reg == scd_pkg::instr_transfer_state) && !leave_instr; // [RULE15]
	assign data_burst_ack = (state_reg == scd_pkg::data_row_strobe_state
		|| state_reg == scd_pkg::data_column_state || state_reg == scd_pkg::data_read_state
		|| state_reg == scd_pkg::data_write_column_state
		|| state_reg == scd_pkg::data_write_state) && !leave_data; // [RULE12]

	// ready and output enables, writes take data one cycle early
	assign instr_ready = state_reg == scd_pkg::instr_transfer_state && instr_burst_request_reg && !bus_invalid_reg; // [RULE18]
	assign data_ready = dbreq_reg && !bus_invalid_reg
		&& (state_reg == scd_pkg::data_read_state
		|| ((state_reg == scd_pkg::data_write_column_state
		|| state_reg == scd_pkg::data_write_state) && fifo_in_ready)); // [RULE3]
	assign instr_oe = instr_ready ? (bank_reg ? 2'h2 : 2'h1) : 2'h0; // [RULE20]
	assign data_oe = data_ready && !write_reg ? (bank_reg ? 2'h2 : 2'h1) : 2'h0;

	default clocking cb @(posedge clk iff clk_en);
	endclocking
	default disable iff (!reset_n);

	sequence s_instr_open;
		state_reg == scd_pkg::instr_row_strobe_state ##1 state_reg == scd_pkg::instr_column_state
			##1 state_reg == scd_pkg::instr_transfer_state;
	endsequence

	sequence s_refresh_run;
		state_reg == scd_pkg::refresh_step_one_state ##1 state_reg == scd_pkg::refresh_step_two_state
			##1 state_reg == scd_pkg::refresh_step_three_state ##1 state_reg == scd_pkg::idle;
	endsequence

	chk_instr_open: assert property (state_reg == scd_pkg::instr_row_strobe_state |-> s_instr_open) // [RULE16]
		else $error("instruction open sequence broken");
	chk_refresh_run: assert property (state_reg == scd_pkg::refresh_step_one_state |-> s_refresh_run) // [RULE23]
		else $error("refresh sequence broken");
	chk_refresh_flag: assert property (state_reg == scd_pkg::refresh_step_one_state |-> refresh_step_first [*3]) // [RULE23]
		else $error("first refresh step dropped early");
	chk_refresh_wins: assert property (state_reg == scd_pkg::idle && refresh_req_reg |=> refresh_step_first) // [RULE14]
		else $error("refresh lost priority");
	chk_idle_quiet: assert property (state_reg == scd_pkg::idle |-> !instr_burst_ack && !data_burst_ack) // [RULE12]
		else $error("ack active in idle");
	chk_irow_outputs: assert property (state_reg == scd_pkg::instr_row_strobe_state |-> // [RULE15]
		instr_burst_ack && !mem_ctl.row_strobe_n && !instr_ready && instr_oe == 2'h0)
		else $error("instruction row outputs wrong");
	chk_pc_idle: assert property (state_reg == scd_pkg::precharge_state |=> state_reg == scd_pkg::idle) // [RULE21]
		else $error("precharge not followed by idle");
	chk_iacc_leave: assert property (leave_instr |=> state_reg == scd_pkg::precharge_state ##1 state_reg == scd_pkg::idle) // [RULE19]
		else $error("transfer exit not via precharge");
	chk_col_delay: assert property ($fell(mem_ctl.row_strobe_n) |-> !mem_ctl.col_select ##1 mem_ctl.col_select) // [RULE8]
		else $error("column select not one cycle after row strobe");
	chk_refresh_period: assert property (ref_cnt_reg == 9'h000 |-> ##[389:389] refresh_tick ##1 refresh_req_reg) // [RULE22]
		else $error("refresh interval wrong");
	chk_write_strobe: assert property (wr_arm_reg |=> !mem_ctl.chip_select_n && !mem_ctl.write_enable_n) // [RULE2]
		else $error("write strobe missing after latch load");
	chk_bank_toggle: assert property (advance && state_reg != scd_pkg::idle |=> bank_reg != $past(bank_reg)) // [RULE7]
		else $error("active bank did not alternate");
	chk_input_reg: assert property (##1 instr_burst_request_reg == $past(instr_burst_request) && bus_invalid_reg == $past(bus_invalid)) // [RULE9]
		else $error("burst request not registered");
endmodule
`default_nettype wire

// [tb/scd_proc_model.sv]
/*
 * processor side model for the scd controller bench: write data source.
 * assumes data_ready marks a word taken at the rising edge.
 */
`default_nettype none
module scd_proc_model (
	input wire logic clk,
	input wire logic reset_n,
	input wire logic data_ready,
	output logic bus_invalid,
	output logic [31:0] write_data
);
	timeunit 1ns;
	timeprecision 1ps;
	// a fresh word follows each word the controller takes
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			write_data <= 32'h1000_0000;
			bus_invalid <= 1'b1;
		end else begin
			bus_invalid <= 1'b0;
			if (data_ready) begin
				write_data <= write_data + 32'h0000_0001; // new word after each cycle with data_ready
			end
		end
	end
endmodule
`default_nettype wire

// [tb/testbench.sv]
/*
 * directed bench for scd_ctrl: decode, bursts, preemption, writes, refresh.
 * assumes the processor model supplies write data and bus_invalid.
 */
`default_nettype none
module testbench;
	timeunit 1ns;
	timeprecision 1ps;
	localparam logic [31:0] A = 32'h0295_3c20; // block 9'h005, even bank
	logic clk = 1'b0;
	logic reset_n = 1'b0;
	logic [31:0] addr = '0;
	logic instr_addr_valid = 1'b0;
	logic data_addr_valid = 1'b0;
	logic data_write = 1'b0;
	logic instr_burst_request = 1'b0;
	logic data_burst_request = 1'b0;
	logic bus_invalid;
	logic [31:0] write_data;
	scd_pkg::scd_decode_type dec;
	scd_pkg::scd_mem_ctl_type mc;
	logic [9:0] ma_even;
	logic [9:0] ma_odd;
	logic [31:0] wd_even;
	logic [31:0] wd_odd;
	logic iack, dack, irdy, drdy, rs1, rs2, rs3, abi;
	logic [1:0] ioe;
	logic [1:0] doe;
	int fails = 0;
	int checked = 0;

	scd_ctrl #(.BLOCK_SELECT(9'h005)) dut (
		.clk(clk), .reset_n(reset_n), .clk_en(1'b1), .addr(addr),
		.instr_addr_valid(instr_addr_valid), .data_addr_valid(data_addr_valid), .data_write(data_write),
		.instr_burst_request(instr_burst_request), .data_burst_request(data_burst_request),
		.bus_invalid(bus_invalid), .write_data(write_data), .access_decode(dec), .mem_ctl(mc),
		.mem_addr_even(ma_even), .mem_addr_odd(ma_odd), .mem_wdata_even(wd_even), .mem_wdata_odd(wd_odd),
		.instr_burst_ack(iack), .data_burst_ack(dack), .instr_ready(irdy), .data_ready(drdy),
		.instr_oe(ioe), .data_oe(doe), .active_bank_indicator(abi),
		.refresh_step_first(rs1), .refresh_step_second(rs2), .refresh_step_third(rs3)
	);
	scd_proc_model partner (
		.clk(clk), .reset_n(reset_n), .data_ready(drdy), .bus_invalid(bus_invalid), .write_data(write_data)
	);

	// 20 mhz clock
	always #25 clk = ~clk;

	// compare and count
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		checked++;
		if (got !== exp) begin
			fails++;
			$display("BAD %0t got %h exp %h", $time, got, exp);
		end
	endtask
	task automatic step();
		@(negedge clk);
	endtask
	task automatic give_verdict();
		if (fails == 0 && checked > 0) begin
			$display("bench passed");
		end else begin
			$display("bench failed");
		end
		$finish;
	endtask
	// steps until the first refresh step rises, bounded
	task automatic wait_rise(output int n);
		n = 0;
		do begin
			step();
			n++;
		end while (rs1 !== 1'b1 && n < 1000);
	endtask

	task automatic t_reset();
		step();
		chk({iack, dack, rs1}, 3'b000);
		chk({mc.row_strobe_n, mc.chip_select_n}, 2'b11);
	endtask
	// an address of another block is not answered
	task automatic t_miss();
		@(posedge clk);
		addr <= 32'h0095_3c20;
		instr_addr_valid <= 1'b1;
		step();
		chk(dec.instr_hit, 0);
		@(posedge clk);
		instr_addr_valid <= 1'b0;
		step();
		chk(iack, 0);
	endtask
	// full instruction burst, suspend, then preempt by a new address
	task automatic t_instr();
		@(posedge clk);
		addr <= A;
		instr_addr_valid <= 1'b1;
		instr_burst_request <= 1'b1;
		step();
		chk({dec.instr_hit, dec.instr_begin}, 2'b11);
		chk(ma_even, A[22:13]);
		@(posedge clk);
		addr <= 32'h0000_0000;
		instr_addr_valid <= 1'b0;
		step();
		chk({iack, mc.row_strobe_n, irdy, ioe}, 5'b10000);
		chk(ma_even, A[22:13]);
		step();
		chk({mc.chip_select_n, mc.col_select, irdy}, 3'b010);
		chk(ma_even, {A[12:10], A[9:3]});
		chk(ma_odd, {A[12:10], A[9:3]});
		for (int i = 0; i < 4; i++) begin
			step();
			chk({irdy, ioe, abi}, {1'b1, i[0] ? 2'b10 : 2'b01, i[0]});
		end
		@(posedge clk);
		instr_burst_request <= 1'b0;
		step();
		chk(irdy, 1);
		step();
		chk({irdy, ioe}, 3'b000);
		@(posedge clk);
		instr_burst_request <= 1'b1;
		step();
		chk({iack, irdy}, 2'b10);
		step();
		chk(irdy, 1);
		@(posedge clk);
		addr <= A;
		instr_addr_valid <= 1'b1;
		step();
		chk({iack, dec.instr_end}, 2'b01);
		step();
		chk({iack, mc.row_strobe_n}, 2'b01);
		@(posedge clk);
		instr_addr_valid <= 1'b0;
		step();
		chk({iack, rs1}, 2'b00);
		step();
		chk(iack, 0);
	endtask
	// write word taken a cycle earlier than a read word, then latched
	task automatic t_write();
		logic [31:0] w;
		@(posedge clk);
		addr <= A;
		data_addr_valid <= 1'b1;
		data_write <= 1'b1;
		data_burst_request <= 1'b1;
		step();
		chk(dec.data_hit, 1);
		@(posedge clk);
		data_addr_valid <= 1'b0;
		step();
		chk({dack, drdy}, 2'b10);
		step();
		chk(drdy, 1);
		w = write_data;
		@(posedge clk);
		data_burst_request <= 1'b0;
		data_write <= 1'b0;
		step();
		step();
		chk(wd_even, w);
		step();
		chk({mc.write_enable_n, mc.chip_select_n}, 2'b00);
		chk(wd_odd, w + 32'h0000_0001);
		step();
		chk(wd_even, w);
		repeat (20) step();
		chk(dack, 0);
	endtask
	// data read burst: ready two cycles after the row cycle, enables alternate
	task automatic t_read();
		@(posedge clk);
		addr <= A;
		data_addr_valid <= 1'b1;
		data_burst_request <= 1'b1;
		step();
		chk({dec.data_hit, dec.data_begin}, 2'b11);
		@(posedge clk);
		data_addr_valid <= 1'b0;
		step();
		chk({dack, drdy}, 2'b10);
		step();
		chk({dack, drdy}, 2'b10);
		step();
		chk({drdy, doe}, 3'b101);
		step();
		chk({drdy, doe}, 3'b110);
		@(posedge clk);
		data_burst_request <= 1'b0;
		step();
		chk({drdy, doe}, 3'b101);
		step();
		chk({dack, drdy, dec.data_end}, 3'b001);
		step();
		chk({dack, mc.row_strobe_n}, 2'b01);
	endtask
	// pending refresh preempts a burst, beats an address, repeats every interval
	task automatic t_refresh();
		int n;
		@(posedge clk);
		addr <= A;
		instr_addr_valid <= 1'b1;
		@(posedge clk);
		instr_addr_valid <= 1'b0;
		step();
		n = 0;
		while (iack === 1'b1 && n < 600) begin
			step();
			n++;
		end
		chk(n < 600, 1);
		@(posedge clk);
		instr_addr_valid <= 1'b1;
		step();
		step();
		chk({iack, mc.chip_select_n}, 2'b00);
		step();
		chk({rs1, rs2, rs3, iack, mc.row_strobe_n}, 5'b10000);
		@(posedge clk);
		instr_addr_valid <= 1'b0;
		step();
		chk({rs1, rs2, rs3}, 3'b110);
		step();
		chk({rs1, rs2, rs3}, 3'b101);
		step();
		chk({rs1, mc.row_strobe_n, iack}, 3'b010);
		wait_rise(n);
		repeat (3) step();
		wait_rise(n);
		chk(n + 3, 390);
	endtask

	// cut a hang short
	initial begin
		#(4000 * 50);
		fails++;
		give_verdict();
	end
	// main sequence
	initial begin
		repeat (16) @(posedge clk);
		reset_n <= 1'b1;
		t_reset();
		t_miss();
		t_instr();
		t_write();
		t_read();
		t_refresh();
		give_verdict();
	end
endmodule
`default_nettype wire
